// ---- hw/pvw_defines.svh ----
`ifndef PVW_DEFINES_SVH
`define PVW_DEFINES_SVH

// register byte offsets
`define PVW_OFS_CTL0     12'h100
`define PVW_OFS_BASE0    12'h104
`define PVW_OFS_BOUND0   12'h108
`define PVW_OFS_XLAT0    12'h10C
`define PVW_OFS_CTL1     12'h114
`define PVW_OFS_BASE1    12'h118
`define PVW_OFS_BOUND1   12'h11C
`define PVW_OFS_XLAT1    12'h120

// control field positions
`define PVW_EN_BIT       31
`define PVW_POSTED_WRITE_ALLOW_BIT     30
`define PVW_VDW_HI       23
`define PVW_VDW_LO       22
`define PVW_VAS_HI       18
`define PVW_VAS_LO       16
`define PVW_PGM_BIT      14
`define PVW_SUPER_BIT    12
`define PVW_VCT_BIT      8
`define PVW_LAS_BIT      0

// writable bits and reset values
`define PVW_CTL_MASK     32'hC0C7_5101
`define PVW_CTL_RST      32'h0080_0000
`define PVW_PAGE_MASK0   32'hFFFF_F000
`define PVW_PAGE_MASK1   32'hFFFF_0000
`define PVW_ADDR_RST     32'h0000_0000

// page granularity, lowest compared bit
`define PVW_GRAN0        12
`define PVW_GRAN1        16

// single-cycle address modifier codes
`define PVW_AM_A16_NP    6'h29
`define PVW_AM_A16_SUP   6'h2D
`define PVW_AM_A24_BASE  3'h7
`define PVW_AM_A32_BASE  3'h1
`define PVW_AM_CSR       6'h2F
`define PVW_AM_USER1     6'h10
`define PVW_AM_USER2     6'h18
`define PVW_AM_NONE      6'h00

`endif

// ---- hw/pvw_pkg.sv ----
package pvw_pkg;

  // far-side address space codes
  typedef enum logic [2:0] {
    PVW_A16   = 3'b000,
    PVW_A24   = 3'b001,
    PVW_A32   = 3'b010,
    PVW_RSV3  = 3'b011,
    PVW_RSV4  = 3'b100,
    PVW_CSR   = 3'b101,
    PVW_USER1 = 3'b110,
    PVW_USER2 = 3'b111
  } pvw_space_e;

  // far-side maximum data width codes
  typedef enum logic [1:0] {
    PVW_W8  = 2'b00,
    PVW_W16 = 2'b01,
    PVW_W32 = 2'b10,
    PVW_W64 = 2'b11
  } pvw_width_e;

endpackage : pvw_pkg

// ---- hw/pvw_window.sv ----
`timescale 1ns/1ps
`include "pvw_defines.svh"

module pvw_window #(
  parameter int unsigned GRAN   = 12,
  parameter bit          CSR_OK = 1'b0
) (
  input  wire logic [31:0] pci_addr,
  input  wire logic        pci_io,
  input  wire logic [31:0] ctl,
  input  wire logic [31:0] floor_addr,
  input  wire logic [31:0] limit_addr,
  input  wire logic [31:0] shift_addr,
  output logic             hit,
  output logic [31:0]      far_addr,
  output logic             blt_ok,
  output logic             mblt_ok,
  output logic             posted
);

  pvw_pkg::pvw_space_e    space;
  pvw_pkg::pvw_width_e    width;
  logic [31-GRAN:0]       page_sum;
  logic                   above;
  logic                   below;
  logic                   open_top;
  logic                   space_ok;
  logic                   wide_space;

  // field decode
  assign space      = pvw_pkg::pvw_space_e'(ctl[`PVW_VAS_HI:`PVW_VAS_LO]);
  assign width      = pvw_pkg::pvw_width_e'(ctl[`PVW_VDW_HI:`PVW_VDW_LO]);
  assign wide_space = (space == pvw_pkg::PVW_A24) || (space == pvw_pkg::PVW_A32);
  // reserved codes claim nothing; csr only where the window allows it
  assign space_ok   = (space != pvw_pkg::PVW_RSV3) && (space != pvw_pkg::PVW_RSV4) &&
                      ((space != pvw_pkg::PVW_CSR) || CSR_OK);

  // page compare, low bits below the granule never take part
  assign above    = pci_addr[31:GRAN] >= floor_addr[31:GRAN];
  assign below    = pci_addr[31:GRAN] < limit_addr[31:GRAN];
  assign open_top = limit_addr[31:GRAN] == '0;
  assign hit      = ctl[`PVW_EN_BIT] &&
                    (pci_io == ctl[`PVW_LAS_BIT]) &&
                    space_ok && above && (open_top || below);

  // translation wraps modulo 2^32 like any two's complement sum
  assign page_sum = pci_addr[31:GRAN] + shift_addr[31:GRAN];
  assign far_addr = {page_sum, pci_addr[GRAN-1:0]};

  // transfer options
  assign blt_ok  = ctl[`PVW_VCT_BIT] && wide_space &&
                   (width != pvw_pkg::PVW_W64);
  assign mblt_ok = wide_space && (width == pvw_pkg::PVW_W64);
  assign posted  = ctl[`PVW_POSTED_WRITE_ALLOW_BIT] && !ctl[`PVW_LAS_BIT];

endmodule : pvw_window

// ---- hw/pvw_top.sv ----
`timescale 1ns/1ps
`include "pvw_defines.svh"

module pvw_top (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [11:0] bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [31:0] bus_rdata_q,
  input  wire logic        dec_valid,
  input  wire logic [31:0] pci_addr,
  input  wire logic        pci_io,
  output logic             dec_done_q,
  output logic             claim_q,
  output logic             win_sel_q,
  output logic      [31:0] far_addr_q,
  output logic      [5:0]  far_am_q,
  output logic      [1:0]  far_width_q,
  output logic             blt_ok_q,
  output logic             mblt_ok_q,
  output logic             posted_q
);

  localparam int NWIN = 2;

  // per-window register map and shapes
  localparam logic [11:0] OFS_CTL   [NWIN] = '{`PVW_OFS_CTL0, `PVW_OFS_CTL1};
  localparam logic [11:0] OFS_BASE  [NWIN] = '{`PVW_OFS_BASE0, `PVW_OFS_BASE1};
  localparam logic [11:0] OFS_BOUND [NWIN] = '{`PVW_OFS_BOUND0, `PVW_OFS_BOUND1};
  localparam logic [11:0] OFS_XLAT  [NWIN] = '{`PVW_OFS_XLAT0, `PVW_OFS_XLAT1};
  localparam logic [31:0] PAGE_MASK [NWIN] = '{`PVW_PAGE_MASK0, `PVW_PAGE_MASK1};

  logic [31:0]     ctl_w   [NWIN];
  logic [31:0]     base_w  [NWIN];
  logic [31:0]     bound_w [NWIN];
  logic [31:0]     xlat_w  [NWIN];
  logic [31:0]     rd_part [NWIN];
  logic [31:0]     far_w   [NWIN];
  logic [NWIN-1:0] hit_w;
  logic [NWIN-1:0] blt_w;
  logic [NWIN-1:0] mblt_w;
  logic [NWIN-1:0] post_w;
  logic [31:0]     rd_mux;
  logic            any_hit;
  logic            pick;
  logic [31:0]     sel_ctl_v;
  logic [5:0]      am_d;
  logic            claim_d;
  logic            ctl1_wr_seen_q;

  genvar w;
  for (w = 0; w < NWIN; w = w + 1) begin : g_win
    logic [31:0] ctl_q;
    logic [31:0] base_q;
    logic [31:0] bound_q;
    logic [31:0] xlat_q;
    wire         hit_ctl   = bus_addr == OFS_CTL[w];
    wire         hit_base  = bus_addr == OFS_BASE[w];
    wire         hit_bound = bus_addr == OFS_BOUND[w];
    wire         hit_xlat  = bus_addr == OFS_XLAT[w];
    wire  [31:0] page_wr   = bus_wdata & PAGE_MASK[w];

    // register storage; bits below the page size stay zero
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        ctl_q   <= `PVW_CTL_RST;
        base_q  <= `PVW_ADDR_RST;
        bound_q <= `PVW_ADDR_RST;
        xlat_q  <= `PVW_ADDR_RST;
      end else if (bus_wr) begin
        if (hit_ctl) begin
          ctl_q <= bus_wdata & `PVW_CTL_MASK;
        end
        if (hit_base) begin
          base_q <= page_wr;
        end
        if (hit_bound) begin
          bound_q <= page_wr;
        end
        if (hit_xlat) begin
          xlat_q <= page_wr;
        end
      end
    end

    // read contributions, reserved bits come back as zero
    assign ctl_w[w]   = ctl_q;
    assign base_w[w]  = base_q;
    assign bound_w[w] = bound_q;
    assign xlat_w[w]  = xlat_q;
    assign rd_part[w] = (hit_ctl   ? ctl_q   : 32'h0000_0000) |
                        (hit_base  ? base_q  : 32'h0000_0000) |
                        (hit_bound ? bound_q : 32'h0000_0000) |
                        (hit_xlat  ? xlat_q  : 32'h0000_0000);

    // window decoder; only window 0 may target csr space
    pvw_window #(
      .GRAN   (w == 0 ? `PVW_GRAN0 : `PVW_GRAN1),
      .CSR_OK (w == 0)
    ) u_window (
      .pci_addr   (pci_addr),
      .pci_io     (pci_io),
      .ctl        (ctl_q),
      .floor_addr (base_q),
      .limit_addr (bound_q),
      .shift_addr (xlat_q),
      .hit        (hit_w[w]),
      .far_addr   (far_w[w]),
      .blt_ok     (blt_w[w]),
      .mblt_ok    (mblt_w[w]),
      .posted     (post_w[w])
    );
  end

  // read mux; unmapped or misaligned offsets read zero
  assign rd_mux = rd_part[0] | rd_part[1];

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_rdata_q <= 32'h0000_0000;
    end else begin
      bus_rdata_q <= bus_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // address modifier for a single cycle of the claiming window
  function automatic logic [5:0] am_code(input logic [31:0] ctl);
    pvw_pkg::pvw_space_e sp;
    logic                pg;
    logic                su;
    logic [1:0]          kind;
    sp   = pvw_pkg::pvw_space_e'(ctl[`PVW_VAS_HI:`PVW_VAS_LO]);
    pg   = ctl[`PVW_PGM_BIT];
    su   = ctl[`PVW_SUPER_BIT];
    kind = pg ? 2'h2 : 2'h1;
    case (sp)
      pvw_pkg::PVW_A16:   am_code = su ? `PVW_AM_A16_SUP : `PVW_AM_A16_NP;
      pvw_pkg::PVW_A24:   am_code = {`PVW_AM_A24_BASE, su, kind};
      pvw_pkg::PVW_A32:   am_code = {`PVW_AM_A32_BASE, su, kind};
      pvw_pkg::PVW_CSR:   am_code = `PVW_AM_CSR;
      pvw_pkg::PVW_USER1: am_code = `PVW_AM_USER1;
      pvw_pkg::PVW_USER2: am_code = `PVW_AM_USER2;
      default:            am_code = `PVW_AM_NONE;
    endcase
  endfunction : am_code

  // window 0 wins an overlap so firmware can punch holes in window 1
  assign any_hit   = |hit_w;
  assign pick      = !hit_w[0];
  assign sel_ctl_v = pick ? ctl_w[1] : ctl_w[0];
  assign claim_d   = dec_valid && any_hit;
  assign am_d      = am_code(sel_ctl_v);

  // decode result, one cycle after the request; zero on a miss
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dec_done_q  <= 1'b0;
      claim_q     <= 1'b0;
      win_sel_q   <= 1'b0;
      far_addr_q  <= 32'h0000_0000;
      far_am_q    <= 6'h00;
      far_width_q <= 2'h0;
      blt_ok_q    <= 1'b0;
      mblt_ok_q   <= 1'b0;
      posted_q    <= 1'b0;
    end else begin
      dec_done_q  <= dec_valid;
      claim_q     <= claim_d;
      win_sel_q   <= claim_d && pick;
      far_addr_q  <= claim_d ? far_w[pick] : 32'h0000_0000;
      far_am_q    <= claim_d ? am_d : 6'h00;
      far_width_q <= claim_d ? sel_ctl_v[`PVW_VDW_HI:`PVW_VDW_LO] : 2'h0;
      blt_ok_q    <= claim_d && blt_w[pick];
      mblt_ok_q   <= claim_d && mblt_w[pick];
      posted_q    <= claim_d && post_w[pick];
    end
  end

  // helper for the reset check: set once window 1 control is written
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl1_wr_seen_q <= 1'b0;
    end else if (bus_wr && (bus_addr == `PVW_OFS_CTL1)) begin
      ctl1_wr_seen_q <= 1'b1;
    end
  end

  // checks of the decode result against the request a cycle earlier
  a_claim_floor: assert property (
    @(posedge clk) disable iff (rst)
    claim_q && !win_sel_q |-> $past(pci_addr[31:12]) >= $past(base_w[0][31:12]))
    else $error("window 0 claimed below its floor");

  a_claim_limit: assert property (
    @(posedge clk) disable iff (rst)
    claim_q && win_sel_q && ($past(bound_w[1][31:16]) != 16'h0000)
    |-> $past(pci_addr[31:16]) < $past(bound_w[1][31:16]))
    else $error("window 1 claimed at or above its limit");

  a_open_limit: assert property (
    @(posedge clk) disable iff (rst)
    dec_valid && ctl_w[1][`PVW_EN_BIT] && (ctl_w[1][`PVW_VAS_HI:`PVW_VAS_LO] == 3'b010) &&
    (pci_io == ctl_w[1][`PVW_LAS_BIT]) && (bound_w[1] == 32'h0000_0000) &&
    (pci_addr[31:16] >= base_w[1][31:16]) |=> claim_q)
    else $error("open window missed an address above its floor");

  a_xlat_win0: assert property (
    @(posedge clk) disable iff (rst)
    claim_q && !win_sel_q
    |-> far_addr_q == {$past(pci_addr[31:12] + xlat_w[0][31:12]), $past(pci_addr[11:0])})
    else $error("window 0 translation wrong");

  a_xlat_win1: assert property (
    @(posedge clk) disable iff (rst)
    claim_q && win_sel_q
    |-> far_addr_q == {$past(pci_addr[31:16] + xlat_w[1][31:16]), $past(pci_addr[15:0])})
    else $error("window 1 translation wrong");

  a_blt_gate: assert property (
    @(posedge clk) disable iff (rst)
    blt_ok_q |-> $past(sel_ctl_v[`PVW_VCT_BIT]) && (far_width_q != 2'b11) && !mblt_ok_q)
    else $error("block transfer allowed without its conditions");

  a_mblt_wide: assert property (
    @(posedge clk) disable iff (rst)
    claim_q && (far_width_q == 2'b11) && ($past(sel_ctl_v[`PVW_VAS_HI:`PVW_VAS_LO]) == 3'b001)
    |-> mblt_ok_q)
    else $error("wide A24 window without multiplexed block option");

  a_io_coupled: assert property (
    @(posedge clk) disable iff (rst)
    claim_q && $past(pci_io) |-> !posted_q)
    else $error("io access marked as posted");

  a_space_match: assert property (
    @(posedge clk) disable iff (rst)
    claim_q |-> $past(pci_io) == $past(sel_ctl_v[`PVW_LAS_BIT]))
    else $error("claim in the wrong pci space");

  a_width_reset: assert property (
    @(posedge clk) disable iff (rst)
    !ctl1_wr_seen_q |-> ctl_w[1][`PVW_VDW_HI:`PVW_VDW_LO] == 2'b10)
    else $error("width field not at its reset code");

  a_am_a32: assert property (
    @(posedge clk) disable iff (rst)
    claim_q && ($past(sel_ctl_v[`PVW_VAS_HI:`PVW_VAS_LO]) == 3'b010)
    |-> far_am_q == {3'b001, $past(sel_ctl_v[`PVW_SUPER_BIT]),
                     $past(sel_ctl_v[`PVW_PGM_BIT]), !$past(sel_ctl_v[`PVW_PGM_BIT])})
    else $error("A32 address modifier wrong");

  a_disabled_win: assert property (
    @(posedge clk) disable iff (rst)
    claim_q |-> (win_sel_q ? $past(ctl_w[1][`PVW_EN_BIT]) : $past(ctl_w[0][`PVW_EN_BIT])))
    else $error("disabled window claimed");

  // a miss must leave nothing behind for the far side to act on
  a_miss_quiet: assert property (
    @(posedge clk) disable iff (rst)
    !claim_q |-> (far_addr_q == 32'h0000_0000) && (far_am_q == 6'h00) && (far_width_q == 2'h0) &&
                 !win_sel_q && !blt_ok_q && !mblt_ok_q && !posted_q)
    else $error("result fields set without a claim");

  a_floor_win1: assert property (
    @(posedge clk) disable iff (rst)
    claim_q && win_sel_q |-> $past(pci_addr[31:16]) >= $past(base_w[1][31:16]))
    else $error("window 1 claimed below its floor");

  a_limit_win0: assert property (
    @(posedge clk) disable iff (rst)
    claim_q && !win_sel_q && ($past(bound_w[0][31:12]) != 20'h00000)
    |-> $past(pci_addr[31:12]) < $past(bound_w[0][31:12]))
    else $error("window 0 claimed at or above its limit");

  a_mblt_width: assert property (
    @(posedge clk) disable iff (rst)
    mblt_ok_q |-> claim_q && (far_width_q == 2'b11) && !blt_ok_q)
    else $error("multiplexed blocks without a 64-bit window");

  // reserved codes never claim; the csr code only counts on window 0
  a_space_legal: assert property (
    @(posedge clk) disable iff (rst)
    claim_q |-> ($past(sel_ctl_v[`PVW_VAS_HI:`PVW_VAS_LO]) != 3'b011) &&
                ($past(sel_ctl_v[`PVW_VAS_HI:`PVW_VAS_LO]) != 3'b100) &&
                !(win_sel_q && ($past(sel_ctl_v[`PVW_VAS_HI:`PVW_VAS_LO]) == 3'b101)))
    else $error("claim through a reserved space code");

endmodule : pvw_top

// ---- testbench/pvw_pci_master.sv ----
`timescale 1ns/1ps
// pci side stand-in: issues queued decode requests, at most one per cycle
module pvw_pci_master (
  input  wire logic        clk,
  output logic             dec_valid,
  output logic      [31:0] pci_addr,
  output logic             pci_io
);
  logic [32:0] req_q[$];  // {io, address}, oldest first
  logic [32:0] cur;

  initial begin
    dec_valid = 1'b0;
    pci_addr  = 32'h0000_0000;
    pci_io    = 1'b0;
  end

  // random idle cycles make a slow master as well as a prompt one
  always @(posedge clk) begin
    if (req_q.size() != 0 && $urandom_range(3) != 0) begin
      cur = req_q.pop_front();
      dec_valid <= 1'b1;
      pci_io    <= cur[32];
      pci_addr  <= cur[31:0];
    end else begin
      dec_valid <= 1'b0;
      pci_addr  <= ~pci_addr;  // stale address must not look like the last one
      pci_io    <= ~pci_io;
    end
  end
endmodule : pvw_pci_master

// ---- testbench/pvw_top_tb.sv ----
`timescale 1ns/1ps
module pvw_top_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] bus_addr = 12'h000;
  logic [31:0] bus_wdata = 32'h0000_0000;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  logic [31:0] bus_rdata_q;
  logic        dec_valid, pci_io, dec_done_q, claim_q, win_sel_q, blt_ok_q, mblt_ok_q, posted_q;
  logic [31:0] pci_addr, far_addr_q;
  logic [5:0]  far_am_q;
  logic [1:0]  far_width_q;
  logic [31:0] r[9];         // register mirror, slot 4 is the hole at 0x110
  logic [44:0] dq[$];        // expected decode results
  logic [31:0] rq[$];        // expected read data
  logic        rd_p = 1'b0;
  logic [31:0] b, a;
  logic [63:0] exp_v;
  wire  [44:0] seen_dec = {claim_q, win_sel_q, far_addr_q, far_am_q, far_width_q, blt_ok_q, mblt_ok_q, posted_q};
  int          w;
  int          mismatches = 0;
  int          n_compared = 0;

  always #4 clk = ~clk;

  pvw_top u_dut (.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata_q(bus_rdata_q), .dec_valid(dec_valid), .pci_addr(pci_addr),
    .pci_io(pci_io), .dec_done_q(dec_done_q), .claim_q(claim_q), .win_sel_q(win_sel_q),
    .far_addr_q(far_addr_q), .far_am_q(far_am_q), .far_width_q(far_width_q), .blt_ok_q(blt_ok_q),
    .mblt_ok_q(mblt_ok_q), .posted_q(posted_q));

  pvw_pci_master u_pm (.clk(clk), .dec_valid(dec_valid), .pci_addr(pci_addr), .pci_io(pci_io));

  function automatic bit mapped(input logic [11:0] ad);
    return ad[1:0] == 2'h0 && ad >= 12'h100 && ad <= 12'h120 && ad != 12'h110;
  endfunction : mapped

  // writable bits per slot: control fields, 4 KB pages, 64 KB pages
  function automatic logic [31:0] msk(input int i);
    return (i == 0 || i == 5) ? 32'hC0C7_5101 : (i < 5) ? 32'hFFFF_F000 : 32'hFFFF_0000;
  endfunction : msk

  // reference decode; window 0 evaluated last so it wins an overlap
  function automatic logic [44:0] model(input logic [31:0] ad, input logic io);
    logic [44:0] res;
    logic [31:0] c, pg;
    logic [2:0]  sp;
    logic [5:0]  am;
    logic        hit, ab;
    res = '0;
    for (int k = 1; k >= 0; k--) begin
      c  = r[k*5];
      sp = c[18:16];
      pg = ad & msk(k*5+1);
      hit = c[31] && io == c[0] && sp != 3'h3 && sp != 3'h4 && !(sp == 3'h5 && k == 1);
      hit = hit && pg >= r[k*5+1] && (r[k*5+2] == 32'h0 || pg < r[k*5+2]);
      ab = sp == 3'h1 || sp == 3'h2;
      case (sp)
        3'h0: am = c[12] ? 6'h2D : 6'h29;
        3'h5: am = 6'h2F;
        3'h6: am = 6'h10;
        3'h7: am = 6'h18;
        default: am = {(sp == 3'h1) ? 3'h7 : 3'h1, c[12], c[14], !c[14]};
      endcase
      if (hit) res = {1'b1, k[0], ad + r[k*5+3], am, c[23:22], c[8] && ab && c[23:22] != 2'h3,
                      ab && c[23:22] == 2'h3, c[30] && !c[0]};
    end
    return res;
  endfunction : model

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk);
    bus_addr  <= ad;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge clk);
    bus_wr    <= 1'b0;
    bus_wdata <= ~d;
    if (mapped(ad)) r[(ad - 12'h100) >> 2] = d & msk((ad - 12'h100) >> 2);
  endtask : wr

  task automatic rd(input logic [11:0] ad);
    @(posedge clk);
    bus_addr <= ad;
    bus_rd   <= 1'b1;
    rq.push_back(mapped(ad) ? r[(ad - 12'h100) >> 2] : 32'h0);
    @(posedge clk);
    bus_rd   <= 1'b0;
  endtask : rd

  task automatic dec(input logic [31:0] ad, input logic io);
    dq.push_back(model(ad, io));
    u_pm.req_q.push_back({io, ad});
  endtask : dec

  task automatic drain;
    for (int i = 0; i < 1000 && u_pm.req_q.size() != 0; i++) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask : drain

  task automatic mirror_reset;
    foreach (r[i]) r[i] = (i == 0 || i == 5) ? 32'h0080_0000 : 32'h0;
  endtask : mirror_reset

  // results stand one cycle; sample them mid-cycle, quiet cycles must read zero
  always @(negedge clk) begin
    if (dec_done_q === 1'b1) begin
      exp_v = dq.size() != 0 ? 64'(dq.pop_front()) : 'x;
      check(64'(seen_dec), exp_v);
    end else begin
      check(64'(seen_dec), 64'h0);
    end
    if (rd_p) check(64'(bus_rdata_q), 64'(rq.pop_front()));
    else check(64'(bus_rdata_q), 64'h0);
    rd_p = bus_rd;
  end

  initial begin
    #400000;
    mismatches++;
    close_out();
  end

  initial begin
    void'($urandom(26));
    mirror_reset();
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    // reset values, holes and misaligned places
    for (int i = 0; i < 10; i++) rd(12'h100 + 12'(i * 4));
    rd(12'h102);
    for (int i = 0; i < 9; i++) wr(12'h100 + 12'(i * 4), 32'hFFFF_FFFF);
    for (int i = 0; i < 9; i++) rd(12'h100 + 12'(i * 4));
    $display("test registers done");
    // window 1 edges, window 0 off, then open-ended limit
    wr(12'h100, 32'h0000_0000);
    wr(12'h104, 32'h0000_0000);
    wr(12'h114, 32'h8082_0000);
    wr(12'h118, 32'h0010_0000);
    wr(12'h11C, 32'h0020_0000);
    wr(12'h120, 32'hFFF0_0000);
    dec(32'h000F_FFFF, 1'b0);
    dec(32'h0010_0000, 1'b0);
    dec(32'h001F_FFFF, 1'b0);
    dec(32'h0020_0000, 1'b0);
    dec(32'h0010_0000, 1'b1);
    drain();
    wr(12'h11C, 32'h0000_0000);
    dec(32'hFFFF_FFFC, 1'b0);
    drain();
    wr(12'h100, 32'h8081_0000);
    wr(12'h104, 32'h0000_1000);
    wr(12'h108, 32'h0000_3000);
    wr(12'h10C, 32'h0000_5000);
    dec(32'h0000_0FFF, 1'b0);
    dec(32'h0000_2FFF, 1'b0);
    dec(32'h0000_3000, 1'b0);
    drain();
    $display("test directed windows done");
    // random controls cover every space, width, block and posting choice
    for (int n = 0; n < 150; n++) begin
      for (int k = 0; k < 2; k++) begin
        b = $urandom;
        wr(12'h100 + 12'(k * 20), $urandom | 32'h8000_0000);
        wr(12'h104 + 12'(k * 20), b);
        wr(12'h108 + 12'(k * 20), ($urandom_range(3) == 0) ? 32'h0 : b + $urandom_range(32'h40000));
        wr(12'h10C + 12'(k * 20), $urandom);
      end
      rd(12'h100 + 12'($urandom_range(9) * 4));
      for (int j = 0; j < 6; j++) begin
        w = $urandom_range(1);
        a = r[w*5+1] + $urandom_range(32'h60000) - 32'h10000;
        dec(a, ($urandom_range(3) == 0) ? ~r[w*5][0] : r[w*5][0]);
      end
      drain();
    end
    $display("test random decode done");
    // second reset in mid-run restores the width default
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    mirror_reset();
    rd(12'h100);
    rd(12'h114);
    rd(12'h11C);
    drain();
    $display("test second reset done");
    check(64'(dq.size()), 64'h0);
    check(64'(rq.size()), 64'h0);
    close_out();
  end
endmodule : pvw_top_tb
